// File: sfspi_consts.svh
// Purpose: Shared constants of the serial flash front end and its host.
// Assumes: Included by bare name; definitions only.
// Notes:   Widths, counts and fill values used by either end.
`ifndef SFSPI_CONSTS_SVH
`define SFSPI_CONSTS_SVH

// ----------------------------------------------------------------
// Data path
// ----------------------------------------------------------------
`define SFSPI_BYTE_W 8
`define SFSPI_FIFO_DEPTH 32
`define SFSPI_FILL_BYTE 8'hff
`define SFSPI_LAST_BIT 3'h7
`define SFSPI_LAST_PAIR 3'h3
`define SFSPI_ZERO3 3'h0

// ----------------------------------------------------------------
// Host framing
// ----------------------------------------------------------------
`define SFSPI_LEN_W 9
`define SFSPI_CNT_W 12
`define SFSPI_CNT_ZERO 12'h000
`define SFSPI_HALF_LAST 4'h7
`define SFSPI_DIV_ZERO 4'h0

`endif

// File: sfspi_dev.sv
// Purpose: Pin level front end of a small serial flash plus its read buffer.
// Assumes: Serial clock is much slower than mclk (at least 8 mclk per half).
// Notes:   All pins pass two flops before use; edges found on mclk.
`timescale 1ns/1ns
`default_nettype none
`include "sfspi_consts.svh"

// ----------------------------------------------------------------
// Read data buffer
// ----------------------------------------------------------------
// Show-ahead FIFO; flags are registered so they stay glitch free.
module sfspi_fifo #(
  parameter int W = `SFSPI_BYTE_W,
  parameter int DEPTH = `SFSPI_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;   // Write position
    logic [AW-1:0] rptr;   // Read position
    logic [AW:0] count;    // Words held
    logic in_ready;        // Not full
    logic out_valid;       // Not empty
  } sfspi_fifo_st_t;

  sfspi_fifo_st_t q;
  sfspi_fifo_st_t d;
  logic [W-1:0] mem [DEPTH];  // Storage words
  logic push;
  logic pop;

  assign in_ready = q.in_ready;
  assign out_valid = q.out_valid;
  assign out_data = mem[q.rptr];

  // Pointer and level update
  always_comb begin
    d = q;
    push = in_valid & q.in_ready;
    pop = out_ready & q.out_valid;
    if (push) begin
      d.wptr = q.wptr + AW'(1);
    end
    if (pop) begin
      d.rptr = q.rptr + AW'(1);
    end
    case ({push, pop})
      2'b10: d.count = q.count + (AW+1)'(1);
      2'b01: d.count = q.count - (AW+1)'(1);
      default: d.count = q.count;
    endcase
    d.in_ready = d.count != (AW+1)'(DEPTH);
    d.out_valid = d.count != (AW+1)'(0);
  end

  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[q.wptr] <= in_data;
    end
  end

endmodule : sfspi_fifo

// ----------------------------------------------------------------
// Device end
// ----------------------------------------------------------------
// Function
// - Low chip select means selected; respond only then.
// - Chip select high deselects; fall back to standby.
// - Serial output released while deselected.
// - Ignore serial input while deselected.
// - Operation starts only on chip select falling.
// - Chip select rising ends and closes command.
// - Self-timed work continues; standby after it ends.
// - Inbound bits sampled on rising serial clock.
// - Output data changes only on falling clock.
// - All inbound bits travel on serial input.
// - Dual read drives input line as second output.
// - Works with clock modes 0 and 3.
// - Serial output carries upper bit of pair.
module sfspi_dev import sfspi_pkg::*; (
  input wire logic mclk,
  input wire logic nrst,
  sfspi_if.dev link,
  input wire logic busy,
  input wire sfspi_txmode_t tx_mode,
  input wire logic rd_valid,
  input wire logic [`SFSPI_BYTE_W-1:0] rd_data,
  output logic rd_ready,
  output logic rx_valid,
  output logic [`SFSPI_BYTE_W-1:0] rx_byte,
  output logic rx_is_op,
  output logic frame_start,
  output logic frame_end,
  output logic standby
);

  sfspi_dev_st_t q;   // Registered state
  sfspi_dev_st_t d;   // Next state
  logic fifo_valid;   // Buffered read byte present
  logic [`SFSPI_BYTE_W-1:0] fifo_data;  // Head of buffer
  logic fifo_pop;     // Take head of buffer

  // ----------------------------------------------------------------
  // Read data buffer between core and shifter
  // ----------------------------------------------------------------
  sfspi_fifo #(
    .W(`SFSPI_BYTE_W),
    .DEPTH(`SFSPI_FIFO_DEPTH)
  ) u_rd_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(rd_valid),
    .in_data(rd_data),
    .in_ready(rd_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  // ----------------------------------------------------------------
  // Outputs straight from flops
  // ----------------------------------------------------------------
  assign link.so_o = q.so_o;
  assign link.so_oe = q.so_oe;
  assign link.io0_d_o = q.io0_o;
  assign link.io0_d_oe = q.io0_oe;
  assign rx_valid = q.rx_valid;
  assign rx_byte = q.rx_byte;
  assign rx_is_op = q.rx_is_op;
  assign frame_start = q.frame_start;
  assign frame_end = q.frame_end;
  assign standby = q.standby;

  // ----------------------------------------------------------------
  // Framing, receive shifter and transmit shifter
  // ----------------------------------------------------------------
  always_comb begin
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic dual;
    logic [`SFSPI_BYTE_W-1:0] next_rx;
    logic [`SFSPI_BYTE_W-1:0] out_byte;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    dual = 1'b0;
    next_rx = '0;
    out_byte = '0;
    d = q;
    fifo_pop = 1'b0;
    // Two flop synchronisers; only the second stage is looked at
    d.cs_s1 = link.cs_n;
    d.cs_s2 = q.cs_s1;
    d.cs_prev = q.cs_s2;
    d.sck_s1 = link.sck;
    d.sck_s2 = q.sck_s1;
    d.sck_prev = q.sck_s2;
    d.si_s1 = link.io0;
    d.si_s2 = q.si_s1;
    // Event strobes last one cycle
    d.rx_valid = 1'b0;
    d.frame_start = 1'b0;
    d.frame_end = 1'b0;
    cs_fall = q.cs_prev & ~q.cs_s2;
    cs_rise = ~q.cs_prev & q.cs_s2;
    // Edges are taken as seen, so either idle level works
    sck_rise = ~q.sck_prev & q.sck_s2;
    sck_fall = q.sck_prev & ~q.sck_s2;
    dual = tx_mode == SFSPI_TX_DUAL;
    if (cs_rise) begin
      // Deselect wins over any clock edge seen in the same cycle
      d.sel = 1'b0;
      d.frame_end = q.sel;
      d.so_oe = 1'b0;
      d.io0_oe = 1'b0;
      d.tx_cnt = `SFSPI_ZERO3;
    end else if (cs_fall) begin
      // Only a falling select opens a frame
      d.sel = 1'b1;
      d.frame_start = 1'b1;
      d.first = 1'b1;
      d.rx_cnt = `SFSPI_ZERO3;
      d.tx_cnt = `SFSPI_ZERO3;
    end else if (q.sel) begin
      // Capture stops once the input line has turned into an output
      if (sck_rise && !q.io0_oe) begin
        next_rx = {q.rx_sr[`SFSPI_BYTE_W-2:0], q.si_s2};
        d.rx_sr = next_rx;
        d.rx_cnt = q.rx_cnt + 3'h1;
        if (q.rx_cnt == `SFSPI_LAST_BIT) begin
          d.rx_valid = 1'b1;
          d.rx_byte = next_rx;
          d.rx_is_op = q.first;
          d.first = 1'b0;
        end
      end
      if (tx_mode == SFSPI_TX_OFF) begin
        d.so_oe = 1'b0;
        d.io0_oe = 1'b0;
      end else if (sck_fall) begin
        // Fresh byte when the last one ran out; underrun sends fill
        if (q.tx_cnt == `SFSPI_ZERO3) begin
          out_byte = fifo_valid ? fifo_data : `SFSPI_FILL_BYTE;
          fifo_pop = fifo_valid;
        end else begin
          out_byte = q.tx_sr;
        end
        d.so_o = out_byte[`SFSPI_BYTE_W-1];
        d.so_oe = 1'b1;
        d.io0_o = out_byte[`SFSPI_BYTE_W-2];
        d.io0_oe = dual;
        if (dual) begin
          d.tx_sr = out_byte << 2;
        end else begin
          d.tx_sr = out_byte << 1;
        end
        if (q.tx_cnt == `SFSPI_ZERO3) begin
          d.tx_cnt = dual ? `SFSPI_LAST_PAIR : `SFSPI_LAST_BIT;
        end else begin
          d.tx_cnt = q.tx_cnt - 3'h1;
        end
      end
    end
    // Standby waits for any self-timed work to finish
    d.standby = ~d.sel & ~busy;
  end

  // State register; chip select idles high so reset matches a quiet bus
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.cs_s1 <= 1'b1;
      q.cs_s2 <= 1'b1;
      q.cs_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule : sfspi_dev

`default_nettype wire

// File: sfspi_host.sv
// Purpose: Host end that frames transfers to the serial flash front end.
// Assumes: One request at a time; write bytes then read bytes.
// Notes:   Serial clock is mclk divided by sixteen.
`timescale 1ns/1ns
`default_nettype none
`include "sfspi_consts.svh"

module sfspi_host import sfspi_pkg::*; (
  input wire logic mclk,
  input wire logic nrst,
  sfspi_if.host link,
  input wire logic req_valid,
  input wire logic req_mode3,
  input wire logic req_dual,
  input wire logic [`SFSPI_LEN_W-1:0] req_wlen,
  input wire logic [`SFSPI_LEN_W-1:0] req_rlen,
  output logic req_ready,
  input wire logic [`SFSPI_BYTE_W-1:0] wr_data,
  output logic wr_taken,
  output logic rd_valid,
  output logic [`SFSPI_BYTE_W-1:0] rd_data,
  output logic done
);

  sfspi_host_st_t q;  // Registered state
  sfspi_host_st_t d;  // Next state

  // ----------------------------------------------------------------
  // Outputs straight from flops
  // ----------------------------------------------------------------
  assign link.cs_n = q.cs_n;
  assign link.sck = q.sck;
  assign link.io0_h_o = q.io0_o;
  assign link.io0_h_oe = q.io0_oe;
  assign req_ready = q.req_ready;
  assign wr_taken = q.wr_taken;
  assign rd_valid = q.rd_valid;
  assign rd_data = q.rd_data;
  assign done = q.done;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Half period is long enough for the far end's input and output
  // synchronisers plus our own before we sample on the rising edge.
  always_comb begin
    logic tick;
    logic [`SFSPI_BYTE_W-1:0] nxt;
    tick = q.div == `SFSPI_HALF_LAST;
    nxt = '0;
    d = q;
    d.so_s1 = link.so;
    d.so_s2 = q.so_s1;
    d.io_s1 = link.io0;
    d.io_s2 = q.io_s1;
    d.wr_taken = 1'b0;
    d.rd_valid = 1'b0;
    d.done = 1'b0;
    d.div = (q.state == SFSPI_H_IDLE || tick) ? `SFSPI_DIV_ZERO : q.div + 4'h1;
    case (q.state)
      SFSPI_H_IDLE: begin
        d.sck = q.mode3;
        if (req_valid && q.req_ready) begin
          d.req_ready = 1'b0;
          d.mode3 = req_mode3;
          d.dual = req_dual;
          d.sck = req_mode3;
          d.cs_n = 1'b0;
          d.wcnt = {req_wlen, 3'h0};
          d.rcnt = req_dual ? {1'b0, req_rlen, 2'h0} : {req_rlen, 3'h0};
          // First bit sits on the line before the first rising edge
          d.wsr = wr_data;
          d.wr_taken = req_wlen != '0;
          d.io0_o = wr_data[`SFSPI_BYTE_W-1];
          d.io0_oe = 1'b1;
          d.wbit = `SFSPI_ZERO3;
          d.rbit = `SFSPI_ZERO3;
          d.state = SFSPI_H_SETUP;
        end
      end
      SFSPI_H_SETUP: begin
        if (tick) begin
          d.sck = 1'b0;
          d.state = SFSPI_H_LOW;
        end
      end
      SFSPI_H_LOW: begin
        if (tick) begin
          d.sck = 1'b1;
          d.state = SFSPI_H_HIGH;
          if (q.wcnt != `SFSPI_CNT_ZERO) begin
            d.wcnt = q.wcnt - `SFSPI_CNT_W'(1);
          end else if (q.rcnt != `SFSPI_CNT_ZERO) begin
            d.rcnt = q.rcnt - `SFSPI_CNT_W'(1);
            // Serial output line is the upper bit of a pair
            nxt = q.dual ? {q.rsr[`SFSPI_BYTE_W-3:0], q.so_s2, q.io_s2} : {q.rsr[`SFSPI_BYTE_W-2:0], q.so_s2};
            d.rsr = nxt;
            d.rbit = q.rbit + 3'h1;
            if (q.rbit == (q.dual ? `SFSPI_LAST_PAIR : `SFSPI_LAST_BIT)) begin
              d.rbit = `SFSPI_ZERO3;
              d.rd_valid = 1'b1;
              d.rd_data = nxt;
            end
          end
        end
      end
      SFSPI_H_HIGH: begin
        if (tick) begin
          if (q.wcnt == `SFSPI_CNT_ZERO && q.rcnt == `SFSPI_CNT_ZERO) begin
            d.sck = q.mode3;
            d.state = SFSPI_H_END;
          end else begin
            d.sck = 1'b0;
            d.state = SFSPI_H_LOW;
            if (q.wcnt != `SFSPI_CNT_ZERO) begin
              // All inbound bits leave on the one input line
              d.wbit = q.wbit + 3'h1;
              nxt = (q.wbit == `SFSPI_LAST_BIT) ? wr_data : q.wsr << 1;
              d.wr_taken = q.wbit == `SFSPI_LAST_BIT;
              d.wsr = nxt;
              d.io0_o = nxt[`SFSPI_BYTE_W-1];
            end else begin
              // In a two line read, let go of the input line before the far end turns it
              d.io0_oe = ~q.dual;
            end
          end
        end
      end
      SFSPI_H_END: begin
        if (tick) begin
          d.cs_n = 1'b1;
          d.done = 1'b1;
          d.req_ready = 1'b1;
          // Input line stays released after a two line read: the far end
          // lets go of it a few cycles after deselect, so take it back
          // only with the next request to avoid a clash
          d.io0_o = 1'b0;
          d.state = SFSPI_H_IDLE;
        end
      end
      default: begin
        d.state = SFSPI_H_IDLE;
      end
    endcase
  end

  // State register; idle with chip select high and ready to accept
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.cs_n <= 1'b1;
      q.io0_oe <= 1'b1;
      q.req_ready <= 1'b1;
      q.state <= SFSPI_H_IDLE;
    end else begin
      q <= d;
    end
  end

endmodule : sfspi_host

`default_nettype wire

// File: sfspi_if.sv
// Purpose: Pin bundle between the flash front end and its host.
// Assumes: Each end drives only its own output and enable signals.
// Notes:   Shared lines resolve here; undriven lines read high.
`timescale 1ns/1ns
`default_nettype none

interface sfspi_if;

  // ----------------------------------------------------------------
  // Host driven pins
  // ----------------------------------------------------------------
  logic cs_n;       // Chip select, active low
  logic sck;        // Serial clock
  logic io0_h_o;    // Host value on serial input line
  logic io0_h_oe;   // Host drives serial input line

  // ----------------------------------------------------------------
  // Device driven pins
  // ----------------------------------------------------------------
  logic so_o;       // Device value on serial output line
  logic so_oe;      // Device drives serial output line
  logic io0_d_o;    // Device value on input line in dual read
  logic io0_d_oe;   // Device drives input line in dual read

  // Resolved wires; a weak pull-up stands in for a floating line
  logic io0;
  logic so;
  assign io0 = io0_h_oe ? io0_h_o : (io0_d_oe ? io0_d_o : 1'b1);
  assign so = so_oe ? so_o : 1'b1;

  modport dev (input cs_n, input sck, input io0, output so_o, output so_oe, output io0_d_o, output io0_d_oe);
  modport host (output cs_n, output sck, output io0_h_o, output io0_h_oe, input io0, input so);

endinterface : sfspi_if

`default_nettype wire

// File: sfspi_link_properties.sv
// Purpose: Pin level checks on the link between flash front end and host.
// Assumes: Every pin is sampled by mclk; one clock domain.
// Notes:   Watches only the pin bundle, never the user sides.
`timescale 1ns/1ns
`default_nettype none

module sfspi_link_properties (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic io0_h_o,
  input wire logic io0_h_oe,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic io0_d_o,
  input wire logic io0_d_oe
);
  // ----------------------------------------------------------------
  // Helper count
  // ----------------------------------------------------------------
  logic [3:0] cs_hi_q; // Cycles with chip select high, saturating
  logic [3:0] cs_hi_d; // Next count
  // Saturate so that long idle gaps never wrap back to zero
  always_comb begin
    cs_hi_d = !cs_n ? 4'h0 : (cs_hi_q == 4'hf ? cs_hi_q : cs_hi_q + 4'h1);
  end
  // Starts saturated: reset leaves the link idle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cs_hi_q <= 4'hf;
    end else begin
      cs_hi_q <= cs_hi_d;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Margin of 5 covers the two sync flops and the edge detect
  a_so_release: assert property (cs_hi_q > 4'h5 |-> !so_oe)
    else $error("serial output driven while deselected");
  a_io_release: assert property (cs_hi_q > 4'h5 |-> !io0_d_oe)
    else $error("input line driven while deselected");
  a_drive_selected: assert property (($rose(so_oe) || $rose(io0_d_oe)) |-> !cs_n)
    else $error("device drive began without selection");
  a_so_fall_only: assert property ((so_oe && $past(so_oe) && $changed(so_o)) |-> !sck)
    else $error("serial output changed outside low clock phase");
  a_dual_fall_only: assert property ((io0_d_oe && $past(io0_d_oe) && $changed(io0_d_o)) |-> !sck)
    else $error("second output changed outside low clock phase");
  a_no_clash: assert property (!(io0_h_oe && io0_d_oe))
    else $error("both ends drive the input line");
  a_half_period: assert property ($changed(sck) |=> $stable(sck) [*7])
    else $error("serial clock half period too short");
  a_si_held: assert property (($rose(sck) && io0_h_oe) |=> $stable(io0_h_o) [*7])
    else $error("input data moved while clock high");
  a_idle_clock: assert property ((cs_n && $past(cs_n)) |-> $stable(sck))
    else $error("serial clock moved between frames");
  a_op_on_si: assert property ($fell(cs_n) |-> io0_h_oe)
    else $error("frame opened without host on input line");

  c_dual: cover property ($rose(io0_d_oe));
  c_single: cover property ($rose(so_oe) && !io0_d_oe);
  c_mode3: cover property ($fell(cs_n) && sck);

endmodule : sfspi_link_properties

`default_nettype wire

// File: sfspi_pkg.sv
// Purpose: Types shared by both ends of the serial flash link.
// Assumes: sfspi_consts.svh is on the include path.
// Notes:   One packed state struct for each of the two ends.
`default_nettype none
`include "sfspi_consts.svh"

package sfspi_pkg;

  // ----------------------------------------------------------------
  // Output modes of the device end
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SFSPI_TX_OFF = 2'b00,
    SFSPI_TX_SINGLE = 2'b01,
    SFSPI_TX_DUAL = 2'b10
  } sfspi_txmode_t;

  // ----------------------------------------------------------------
  // Host sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SFSPI_H_IDLE = 3'b000,
    SFSPI_H_SETUP = 3'b001,
    SFSPI_H_LOW = 3'b010,
    SFSPI_H_HIGH = 3'b011,
    SFSPI_H_END = 3'b100
  } sfspi_hstate_t;

  // Device end state
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_prev;
    logic sck_s1;
    logic sck_s2;
    logic sck_prev;
    logic si_s1;
    logic si_s2;
    logic sel;
    logic [`SFSPI_BYTE_W-1:0] rx_sr;
    logic [2:0] rx_cnt;
    logic first;
    logic rx_valid;
    logic [`SFSPI_BYTE_W-1:0] rx_byte;
    logic rx_is_op;
    logic frame_start;
    logic frame_end;
    logic [`SFSPI_BYTE_W-1:0] tx_sr;
    logic [2:0] tx_cnt;
    logic so_o;
    logic so_oe;
    logic io0_o;
    logic io0_oe;
    logic standby;
  } sfspi_dev_st_t;

  // Host end state
  typedef struct packed {
    sfspi_hstate_t state;
    logic [3:0] div;
    logic mode3;
    logic dual;
    logic [`SFSPI_CNT_W-1:0] wcnt;
    logic [`SFSPI_CNT_W-1:0] rcnt;
    logic [`SFSPI_BYTE_W-1:0] wsr;
    logic [2:0] wbit;
    logic [`SFSPI_BYTE_W-1:0] rsr;
    logic [2:0] rbit;
    logic so_s1;
    logic so_s2;
    logic io_s1;
    logic io_s2;
    logic cs_n;
    logic sck;
    logic io0_o;
    logic io0_oe;
    logic req_ready;
    logic wr_taken;
    logic rd_valid;
    logic [`SFSPI_BYTE_W-1:0] rd_data;
    logic done;
  } sfspi_host_st_t;

endpackage : sfspi_pkg

`default_nettype wire

// File: tb_serial_flash_spi_front_end.sv
// Purpose: Self-checking bench joining host and flash front end.
// Assumes: Host makes its own serial clock from mclk.
// Notes:   Device user side is played by a small responder process.
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_serial_flash_spi_front_end import sfspi_pkg::*;;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk, nrst, busy, rd_valid, rd_ready, rx_valid, rx_is_op;
  logic frame_start, frame_end, standby, req_valid, req_mode3, req_dual;
  logic req_ready, wr_taken, h_rd_valid, done;
  logic [7:0] rd_data, rx_byte, wr_data, h_rd_data;
  logic [8:0] req_wlen, req_rlen;
  sfspi_txmode_t tx_mode;
  int errors, n_tests, nfs, nfe, nd, wi, wl, rl, got;
  logic dl; // Current frame reads on two lines
  logic [7:0] wq[$], eq[$], rdq[$]; // Sent, expected and read bytes
  logic [8:0] rxq[$]; // Captured bytes with opcode flag on top

  sfspi_if sfspi_if_inst ();
  sfspi_dev sfspi_dev_inst (.mclk(mclk), .nrst(nrst), .link(sfspi_if_inst), .busy(busy),
    .tx_mode(tx_mode), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_is_op(rx_is_op), .frame_start(frame_start),
    .frame_end(frame_end), .standby(standby));
  sfspi_host sfspi_host_inst (.mclk(mclk), .nrst(nrst), .link(sfspi_if_inst),
    .req_valid(req_valid), .req_mode3(req_mode3), .req_dual(req_dual), .req_wlen(req_wlen),
    .req_rlen(req_rlen), .req_ready(req_ready), .wr_data(wr_data), .wr_taken(wr_taken),
    .rd_valid(h_rd_valid), .rd_data(h_rd_data), .done(done));
  sfspi_link_properties sfspi_link_properties_inst (.mclk(mclk), .nrst(nrst),
    .cs_n(sfspi_if_inst.cs_n), .sck(sfspi_if_inst.sck), .io0_h_o(sfspi_if_inst.io0_h_o),
    .io0_h_oe(sfspi_if_inst.io0_h_oe), .so_o(sfspi_if_inst.so_o), .so_oe(sfspi_if_inst.so_oe),
    .io0_d_o(sfspi_if_inst.io0_d_o), .io0_d_oe(sfspi_if_inst.io0_d_oe));

  // Clock, 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Responder: looks 1 ns after each rising edge so pulses have settled
  // ----------------------------------------------------------------
  always begin
    @(posedge mclk);
    #1;
    if (rx_valid) begin
      rxq.push_back({rx_is_op, rx_byte});
      // Turn the output on before the next falling clock
      if (rxq.size() == wl && rl > 0) tx_mode = dl ? SFSPI_TX_DUAL : SFSPI_TX_SINGLE;
    end
    if (frame_end) tx_mode = SFSPI_TX_OFF;
    if (h_rd_valid) rdq.push_back(h_rd_data);
    if (wr_taken && wi + 1 < wq.size()) begin
      wi++;
      wr_data = wq[wi];
    end
    nfs += int'(frame_start);
    nfe += int'(frame_end);
    nd += int'(done);
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Offer n bytes to the read buffer; keeps valid up between beats
  task automatic load(input int n);
    got = 0;
    rd_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      rd_data = 8'(i * 37 + 5);
      if (rd_ready === 1'b1) begin
        eq.push_back(rd_data);
        got++;
      end
      @(posedge mclk);
      #1;
    end
    rd_valid = 1'b0;
  endtask : load

  // One frame: w bytes written from wq, r bytes read and compared to eq
  task automatic xfer(input logic m3, input logic d, input int w, input int r);
    int k, fs, fe, dn;
    rxq = {};
    rdq = {};
    wl = w;
    rl = r;
    dl = d;
    wi = 0;
    fs = nfs;
    fe = nfe;
    dn = nd;
    k = 0;
    wr_data = wq[0];
    req_mode3 = m3;
    req_dual = d;
    req_wlen = 9'(w);
    req_rlen = 9'(r);
    req_valid = 1'b1;
    @(posedge mclk);
    #1 req_valid = 1'b0;
    repeat (20) @(posedge mclk);
    #1 `CHK(standby, 1'b0)
    `CHK(req_ready, 1'b0)
    // Bounded wait on completion
    while (nd == dn && k < 20000) begin
      @(posedge mclk);
      k++;
    end
    repeat (6) @(posedge mclk);
    #1 `CHK(nfs - fs, 1)
    `CHK(nfe - fe, 1)
    `CHK(standby, ~busy)
    // Single read keeps sampling the held input line, one byte per read
    `CHK(rxq.size(), d ? w : w + r)
    foreach (rxq[i]) if (i < w) `CHK(rxq[i], {i == 0, wq[i]})
    `CHK(rdq.size(), r)
    foreach (rdq[i]) `CHK(rdq[i], eq[i])
    `CHK(req_ready, 1'b1)
    `CHK(sfspi_if_inst.sck, m3)
    `CHK(sfspi_if_inst.so_oe, 1'b0)
    `CHK(sfspi_if_inst.io0_d_oe, 1'b0)
  endtask : xfer

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Opcode then two data bytes, clock mode 0
  task automatic t_write();
    wq = '{8'h02, 8'ha5, 8'h3c};
    eq = {};
    xfer(1'b0, 1'b0, 3, 0);
  endtask : t_write

  // Single line read in clock mode 3
  task automatic t_read_single();
    eq = {};
    load(4);
    wq = '{8'h0b};
    xfer(1'b1, 1'b0, 1, 4);
  endtask : t_read_single

  // Two line read; second bit of each pair on the input line
  task automatic t_read_dual();
    eq = {};
    load(2);
    wq = '{8'h3b};
    xfer(1'b0, 1'b1, 1, 2);
  endtask : t_read_dual

  // Fill the buffer until refused, then drain past empty
  task automatic t_fill();
    eq = {};
    load(33);
    `CHK(got, 32)
    `CHK(rd_ready, 1'b0)
    eq.push_back(8'hff);
    wq = '{8'h03};
    xfer(1'b0, 1'b0, 1, 33);
    `CHK(rd_ready, 1'b1)
  endtask : t_fill

  // Self-timed work keeps the device out of standby after deselect
  task automatic t_busy();
    busy = 1'b1;
    eq = {};
    wq = '{8'h06};
    xfer(1'b1, 1'b0, 1, 0);
    repeat (10) @(posedge mclk);
    #1 `CHK(standby, 1'b0)
    busy = 1'b0;
    repeat (3) @(posedge mclk);
    #1 `CHK(standby, 1'b1)
  endtask : t_busy

  // Verdict and end of run
  task automatic wrap_up();
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, busy, rd_valid, rd_data, req_valid, req_mode3, req_dual} = '0;
    {req_wlen, req_rlen, wr_data} = '0;
    tx_mode = SFSPI_TX_OFF;
    {errors, n_tests, nfs, nfe, nd, wi, wl, rl} = '0;
    dl = 1'b0;
    repeat (2) @(posedge mclk);
    #1 `CHK(sfspi_if_inst.cs_n, 1'b1)
    `CHK(sfspi_if_inst.so_oe, 1'b0)
    nrst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 `CHK(standby, 1'b1)
    t_write();
    t_read_single();
    t_read_dual();
    t_fill();
    t_busy();
    wrap_up();
  end

  // Watchdog: about three times the expected run
  initial begin
    #2000000;
    errors++;
    wrap_up();
  end

endmodule : tb_serial_flash_spi_front_end

`default_nettype wire
